/* hw/host_port_pkg.sv */
package host_port_pkg;

	// ==========================================================
	// Widths
	localparam int ADDR_W = 14;
	localparam int DATA_W = 16;
	localparam int DECODE_W = 12;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int ACCESS_MIN_NS = 180;
	// Shortest strobe: half a bus clock of a compressed cycle (8.33 MHz)
	localparam int STROBE_MIN_NS = 60;
	localparam int STROBE_MIN_CYC = (STROBE_MIN_NS / CLK_PERIOD_NS < 1) ? 1 :
		STROBE_MIN_NS / CLK_PERIOD_NS;
	// Read data must appear well inside the shortest strobe
	localparam int READ_LAT_CYC = 2;

	// ==========================================================
	// Reset values and decode
	localparam logic [DECODE_W-1:0] IO_BASE_RST = 12'h030;
	localparam logic [15:0] DATA_RST = 16'h0000;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic byte_en_lo_n;
		logic byte_en_hi_n;
		logic io_qual_n;
	} addr_phase_s;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic lane_lo;
		logic lane_hi;
	} data_beat_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE
	} access_e;

endpackage

/* hw/strobe_edge.sv */
`timescale 1ns/1ns
`default_nettype none
module strobe_edge
	import host_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic strobe_n,
	output logic fall,
	output logic rise
);
	logic prev;

	always_ff @(posedge clk) begin
		if (rst) begin
			prev <= 1'b1;
		end else begin
			prev <= strobe_n;
		end
	end

	assign fall = prev & ~strobe_n;
	assign rise = ~prev & strobe_n;
endmodule
`default_nettype wire

/* hw/eisa_io_slave_host_port.sv */
`timescale 1ns/1ns
`default_nettype none
module eisa_io_slave_host_port
	import host_port_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic ADDR_STROBE_N,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic IO_QUAL_N,
	input wire logic BYTE_EN_LO_N,
	input wire logic BYTE_EN_HI_N,
	input wire logic READ_STROBE_N,
	input wire logic WRITE_STROBE_N,
	input wire logic [DATA_W-1:0] DATA_IN,
	output logic [DATA_W-1:0] DATA_OUT,
	output logic DATA_OE_LO,
	output logic DATA_OE_HI,
	output logic DECODE_HIT_N,
	output logic IRQ_OUT,
	input wire logic IRQ_REQ,
	input wire logic [DECODE_W-1:0] IO_BASE,
	input wire logic [DATA_W-1:0] RD_DATA,
	output logic [ADDR_W-1:0] REG_ADDR,
	output logic [DATA_W-1:0] WR_DATA,
	output logic WR_LANE_LO,
	output logic WR_LANE_HI,
	output logic WR_PULSE,
	output logic RD_PULSE
);
	// ==========================================================
	// Address phase
	addr_phase_s held;
	addr_phase_s live;
	logic ads_fall;
	logic ads_rise;
	logic rd_fall;
	logic rd_rise;
	logic wr_fall;
	logic wr_rise;
	logic irq_prev;
	access_e state;

	strobe_edge u_ads (.clk(CORE_CLK), .rst(RESET), .strobe_n(ADDR_STROBE_N),
		.fall(ads_fall), .rise(ads_rise));
	strobe_edge u_rd (.clk(CORE_CLK), .rst(RESET), .strobe_n(READ_STROBE_N),
		.fall(rd_fall), .rise(rd_rise));
	strobe_edge u_wr (.clk(CORE_CLK), .rst(RESET), .strobe_n(WRITE_STROBE_N),
		.fall(wr_fall), .rise(wr_rise));

	// Transparent while strobe is low, frozen once it rises
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			held <= '{addr: '0, byte_en_lo_n: 1'b1, byte_en_hi_n: 1'b1,
				io_qual_n: 1'b1};
		end else if (!ADDR_STROBE_N) begin
			held.addr <= ADDR;
			held.io_qual_n <= IO_QUAL_N;
			held.byte_en_lo_n <= BYTE_EN_LO_N;
			held.byte_en_hi_n <= BYTE_EN_HI_N;
		end
	end

	// Inputs seen this cycle while the strobe is still low
	always_comb begin
		live = held;
		if (!ADDR_STROBE_N) begin
			live = '{addr: ADDR, byte_en_lo_n: BYTE_EN_LO_N,
				byte_en_hi_n: BYTE_EN_HI_N, io_qual_n: IO_QUAL_N};
		end
	end

	// ==========================================================
	// Decode
	logic hit;
	assign hit = (live.addr[ADDR_W-1:2] == IO_BASE) && !live.io_qual_n;

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			DECODE_HIT_N <= 1'b1;
		end else begin
			DECODE_HIT_N <= ~hit;
		end
	end

	// ==========================================================
	// Lanes
	data_beat_s lanes;
	always_comb begin
		lanes.data = DATA_IN;
		lanes.lane_lo = !held.byte_en_lo_n;
		lanes.lane_hi = !held.byte_en_hi_n;
	end

	// ==========================================================
	// Access sequencing: single-cycle reaction keeps half-clock strobes safe
	logic held_hit;
	assign held_hit = (held.addr[ADDR_W-1:2] == IO_BASE) && !held.io_qual_n;

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (rd_fall && held_hit) begin
						state <= ST_READ;
					end else if (wr_fall && held_hit) begin
						state <= ST_WRITE;
					end
				end
				ST_READ: begin
					if (READ_STROBE_N) begin
						state <= ST_IDLE;
					end
				end
				ST_WRITE: begin
					if (WRITE_STROBE_N) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Read path: enables registered, set on the clock edge that first sees the strobe low; data loaded every clock
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			DATA_OUT <= DATA_RST;
			DATA_OE_LO <= 1'b0;
			DATA_OE_HI <= 1'b0;
			RD_PULSE <= 1'b0;
		end else begin
			RD_PULSE <= rd_fall && held_hit;
			DATA_OUT <= RD_DATA;
			DATA_OE_LO <= !READ_STROBE_N && held_hit && lanes.lane_lo;
			DATA_OE_HI <= !READ_STROBE_N && held_hit && lanes.lane_hi;
		end
	end

	// Write path: data captured on the strobe's trailing edge
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			WR_DATA <= DATA_RST;
			WR_LANE_LO <= 1'b0;
			WR_LANE_HI <= 1'b0;
			WR_PULSE <= 1'b0;
			REG_ADDR <= '0;
		end else begin
			WR_PULSE <= wr_rise && state == ST_WRITE;
			REG_ADDR <= held.addr;
			if (wr_rise && state == ST_WRITE) begin
				WR_DATA <= lanes.data;
				WR_LANE_LO <= lanes.lane_lo;
				WR_LANE_HI <= lanes.lane_hi;
			end
		end
	end

	// ==========================================================
	// Interrupt: level passed registered so the bus sees a clean rising edge
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			IRQ_OUT <= 1'b0;
			irq_prev <= 1'b0;
		end else begin
			IRQ_OUT <= IRQ_REQ;
			irq_prev <= IRQ_OUT;
		end
	end

	// ==========================================================
	// Checks
	sequence s_write_end;
		state == ST_WRITE ##1 wr_rise;
	endsequence

	AST_ADDR_HOLD: assert property (@(posedge CORE_CLK)
		disable iff (RESET)
		ADDR_STROBE_N && $past(ADDR_STROBE_N) |-> $stable(held.addr))
		else $error("address changed while strobe high");
	AST_QUAL_FOLLOW: assert property (@(posedge CORE_CLK)
		disable iff (RESET)
		!ADDR_STROBE_N |=> held.io_qual_n == $past(IO_QUAL_N))
		else $error("qualify not transparent");
	AST_BE_HOLD: assert property (@(posedge CORE_CLK)
		disable iff (RESET)
		ADDR_STROBE_N && $past(ADDR_STROBE_N) |-> $stable(held.byte_en_lo_n)
		&& $stable(held.byte_en_hi_n))
		else $error("byte enables changed during access");
	AST_DECODE: assert property (@(posedge CORE_CLK)
		disable iff (RESET)
		1'b1 |=> DECODE_HIT_N == !$past(hit))
		else $error("decode output wrong");
	// Judged from the pins themselves, not from the internal hit term
	AST_DECODE_PINS: assert property (@(posedge CORE_CLK)
		disable iff (RESET)
		!ADDR_STROBE_N |=> DECODE_HIT_N ==
		!$past((ADDR[ADDR_W-1:2] == IO_BASE) && !IO_QUAL_N))
		else $error("decode output ignores address pins");
	AST_READ_DRIVE: assert property (@(posedge CORE_CLK)
		disable iff (RESET)
		!READ_STROBE_N && held_hit && lanes.lane_lo |=> DATA_OE_LO)
		else $error("read lane not driven");
	AST_LANE_FLOAT: assert property (@(posedge CORE_CLK)
		disable iff (RESET)
		held.byte_en_hi_n && ADDR_STROBE_N |=> !DATA_OE_HI)
		else $error("unused upper lane driven");
	AST_WRITE_TAKE: assert property (@(posedge CORE_CLK)
		disable iff (RESET)
		s_write_end |=> WR_PULSE && WR_DATA == $past(DATA_IN))
		else $error("write data not taken");
	AST_FAST_DONE: assert property (@(posedge CORE_CLK)
		disable iff (RESET)
		WR_PULSE |-> ##[0:2] state == ST_IDLE)
		else $error("access did not finish");
	AST_IRQ_EDGE: assert property (@(posedge CORE_CLK)
		disable iff (RESET)
		$rose(IRQ_REQ) |=> IRQ_OUT && !irq_prev)
		else $error("interrupt edge missing");
endmodule
`default_nettype wire

/* tb/eisa_glue_model.sv */
`timescale 1ns/1ns
`default_nettype none
module eisa_glue_model
	import host_port_pkg::*;
(
	input wire logic clk,
	input wire logic hit_n,
	input wire data_beat_s beat,
	output addr_phase_s ap_pins,
	output logic as_n,
	output logic rd_n,
	output logic wr_n,
	output logic [DATA_W-1:0] din
);
	logic no_wait_req_n;

	// No-wait request follows the decode but drops once start rises
	assign no_wait_req_n = hit_n | as_n;

	// ==========================================================
	// Idle bus
	initial begin
		as_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		ap_pins = '1;
		din = '0;
	end

	// ==========================================================
	// One access: start phase, then a command strobe wid cycles wide
	task automatic access(input logic wr, input addr_phase_s ap,
		input logic [DATA_W-1:0] d, input int wid,
		output logic got_hit_n, output data_beat_s got);
		as_n <= 1'b0;
		ap_pins <= ap;
		repeat (2) @(posedge clk);
		got_hit_n = no_wait_req_n;
		as_n <= 1'b1;
		@(posedge clk);
		// Lines move on after start, so the port must rely on its latch
		ap_pins <= ~ap;
		wr_n <= !wr;
		rd_n <= wr;
		din <= d;
		repeat (wid) @(posedge clk);
		got = beat;
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		@(posedge clk);
		din <= ~d;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

/* tb/eisa_io_slave_host_port_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("[ERR] %0t got %h want %h", $time, got, exp); \
	end \
end
module eisa_io_slave_host_port_tb_top import host_port_pkg::*;;
	// ==========================================================
	// Signals
	logic core_clk, irq_out, oe_lo, oe_hi, hit_n, as_n, rd_n, wr_n;
	logic reset = 1'b1;
	logic irq_req = 1'b0;
	logic [DATA_W-1:0] rd_data = '0;
	logic [DATA_W-1:0] data_out, wr_data, din;
	logic [ADDR_W-1:0] reg_addr;
	logic lane_lo, lane_hi, wr_pulse, rd_pulse;
	int rd_pulses = 0;
	addr_phase_s ap_pins;
	int miscompares = 0;
	int comparisons = 0;
	localparam logic [ADDR_W-1:0] hit_addr = {IO_BASE_RST, 2'h1};
	localparam logic [15:0] exp_rd = {2'h0, hit_addr} ^ 16'hA5A5;

	eisa_io_slave_host_port eisa_io_slave_host_port_inst (
		.CORE_CLK(core_clk), .RESET(reset), .ADDR_STROBE_N(as_n),
		.ADDR(ap_pins.addr), .IO_QUAL_N(ap_pins.io_qual_n),
		.BYTE_EN_LO_N(ap_pins.byte_en_lo_n),
		.BYTE_EN_HI_N(ap_pins.byte_en_hi_n),
		.READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .DATA_IN(din),
		.DATA_OUT(data_out), .DATA_OE_LO(oe_lo), .DATA_OE_HI(oe_hi),
		.DECODE_HIT_N(hit_n), .IRQ_OUT(irq_out), .IRQ_REQ(irq_req),
		.IO_BASE(IO_BASE_RST), .RD_DATA(rd_data), .REG_ADDR(reg_addr),
		.WR_DATA(wr_data), .WR_LANE_LO(lane_lo), .WR_LANE_HI(lane_hi),
		.WR_PULSE(wr_pulse), .RD_PULSE(rd_pulse));
	eisa_glue_model glue_inst (.clk(core_clk), .hit_n(hit_n),
		.beat({data_out, oe_lo, oe_hi}), .ap_pins(ap_pins), .as_n(as_n),
		.rd_n(rd_n), .wr_n(wr_n), .din(din));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Core register file stand-in: word depends on the address asked
	always @(posedge core_clk) rd_data <= {2'h0, reg_addr} ^ 16'hA5A5;
	// Read starts seen; unknown before reset is not counted
	always @(posedge core_clk) if (rd_pulse === 1'b1) rd_pulses <= rd_pulses + 1;

	// ==========================================================
	// Helpers
	function automatic addr_phase_s mk(logic lo, logic hi, logic q);
		return {hit_addr, lo, hi, q};
	endfunction
	task automatic count_wr(output int n);
		n = 0;
		// The pulse may already stand when the access returns
		repeat (5) begin
			n += wr_pulse;
			@(posedge core_clk);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic test_read();
		logic h;
		data_beat_s b;
		logic [1:0] be;
		logic [15:0] m;
		for (int i = 0; i < 3; i++) begin
			be = 2'(i);
			m = {{8{~be[0]}}, {8{~be[1]}}};
			glue_inst.access(1'b0, mk(be[1], be[0], 1'b0), '0, 12, h, b);
			`CHECK(h, 1'b0)
			`CHECK({b.lane_lo, b.lane_hi}, ~be)
			`CHECK(b.data & m, exp_rd & m)
		end
		`CHECK(rd_pulses, 3)
		$display("test_read done");
	endtask
	task automatic test_write();
		logic h;
		data_beat_s b;
		int n;
		// Compressed cycle: strobe only half a bus clock wide
		glue_inst.access(1'b1, mk(1'b0, 1'b1, 1'b0), 16'h5AC3,
			STROBE_MIN_CYC, h, b);
		count_wr(n);
		`CHECK(n, 1)
		`CHECK(wr_data, 16'h5AC3)
		`CHECK({lane_lo, lane_hi}, 2'b10)
		`CHECK(reg_addr, hit_addr)
		$display("test_write done");
	endtask
	task automatic test_miss();
		logic h;
		data_beat_s b;
		int n;
		addr_phase_s ap;
		ap = mk(1'b0, 1'b0, 1'b0);
		ap.addr[ADDR_W-1] = ~ap.addr[ADDR_W-1];
		glue_inst.access(1'b0, ap, '0, 12, h, b);
		`CHECK(h, 1'b1)
		`CHECK({b.lane_lo, b.lane_hi}, 2'b00)
		glue_inst.access(1'b0, mk(1'b0, 1'b0, 1'b1), '0, 12, h, b);
		`CHECK(h, 1'b1)
		`CHECK({b.lane_lo, b.lane_hi}, 2'b00)
		glue_inst.access(1'b1, mk(1'b0, 1'b0, 1'b1), 16'h1234, 12, h, b);
		count_wr(n);
		`CHECK(n, 0)
		`CHECK(rd_pulses, 3)
		$display("test_miss done");
	endtask
	task automatic test_irq();
		int k;
		irq_req <= 1'b1;
		k = 0;
		while (irq_out !== 1'b1 && k < 4) begin
			@(posedge core_clk);
			k++;
		end
		`CHECK(irq_out, 1'b1)
		// A timeout is already counted; fall through to the report
		if (irq_out === 1'b1) begin
			irq_req <= 1'b0;
			repeat (3) @(posedge core_clk);
			`CHECK(irq_out, 1'b0)
		end
		$display("test_irq done");
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		`CHECK({hit_n, oe_lo, oe_hi, irq_out}, 4'h8)
		test_read();
		test_write();
		test_miss();
		test_irq();
		print_verdict();
	end
endmodule
`default_nettype wire
